// ### include/ela_pkg.sv
// Constants and types shared by the exception latch and arbiter
package ela_pkg;

    // *************************************************
    // Sizes
    // *************************************************
    localparam int NUM_SRC = 17;
    localparam int SRC_W = 5;
    localparam int NUM_EV = 4;
    localparam logic [2:0] PUSH_LAST = 3'h4;

    // *************************************************
    // Register byte addresses
    // *************************************************
    localparam logic [15:0] ADDR_PEND_LOW = 16'hFE04;
    localparam logic [15:0] ADDR_PEND_MID = 16'hFE05;
    localparam logic [15:0] ADDR_PEND_HIGH = 16'hFE06;
    localparam logic [15:0] ADDR_INT_STATUS = 16'hFE08;
    localparam logic [15:0] ADDR_INT_CLEAR = 16'hFE09;
    localparam logic [15:0] ADDR_INT_ENABLE = 16'hFE0A;
    localparam logic [15:0] ADDR_SRC_EN_LOW = 16'hFE0C;
    localparam logic [15:0] ADDR_SRC_EN_MID = 16'hFE0D;
    localparam logic [15:0] ADDR_SRC_EN_HIGH = 16'hFE0E;

    // *************************************************
    // Reset values and field positions
    // *************************************************
    localparam logic [7:0] PEND_RESET = 8'h00;
    localparam logic [7:0] SRC_EN_RESET = 8'hFF;
    localparam logic [NUM_EV-1:0] INT_EN_RESET = 4'h0;
    localparam logic [7:0] LOW_USED = 8'hFC;
    localparam logic [7:0] HIGH_USED = 8'h07;
    localparam int CCR_I_BIT = 3;
    localparam int EV_HW = 0;
    localparam int EV_SWI = 1;
    localparam int EV_BRK = 2;
    localparam int EV_RTI = 3;

    // *************************************************
    // Vectors and stacking
    // *************************************************
    localparam logic [15:0] VEC_IF1 = 16'hFFFA;
    localparam logic [15:0] VEC_SWI = 16'hFFFC;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] HW_PC_ADJ = 16'h0001;

    // *************************************************
    // Sequencer states and entry kinds
    // *************************************************
    typedef enum logic [2:0] {ST_RUN, ST_PUSH, ST_VEC, ST_POP, ST_POPW, ST_RESUME} ela_state_e;
    typedef enum logic [1:0] {KIND_HW, KIND_SWI, KIND_BRK} ela_kind_e;

endpackage : ela_pkg

// ### verilog/ela_top.sv
// Exception latch, arbiter and stacking sequencer of the integration unit
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Entry stacks registers, then sets mask bit
// - Return restores stacked registers from stack
// - Latch requests, arbitrate, output vector constant
// - Latched request cannot be preempted until serviced
// - Requests wait for instruction completion
// - Boundary check: mask clear and enable set
// - Highest fixed priority request served first
// - Pending request served right after return
// - Index high register is never stacked
// - Software trap ignores the mask bit
// - Trap stacks PC, hardware stacks PC-1
// - Flag n vectors downward from top
// - Pending flag reads one while requested
// - Middle status holds flags 14..7, read-only
// - Low status flags 6..1, bits 1:0 zero
// - High status shows flags 17..15
// - Resets outrank all, bypass arbitration
// - Break forces the software trap vector
// - Reset selects reset vector, clears status, enables all sources
module ela_top
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Reset sources from the rest of the chip
    input wire logic [5:0] rst_src,
    output logic internal_reset,
    // Peripheral requests, index equals flag number
    input wire logic [ela_pkg::NUM_SRC:1] irq_req,
    // Core instruction boundary and events
    input wire logic instr_done,
    input wire logic swi_exec,
    input wire logic rti_exec,
    input wire logic brk_req,
    input wire logic cli_req,
    input wire logic sei_req,
    // Core register snapshot
    input wire logic [15:0] core_pc,
    input wire logic [7:0] core_x,
    input wire logic [7:0] core_a,
    input wire logic [7:0] core_ccr,
    // Stack port
    output logic push_valid,
    output logic [7:0] push_data,
    output logic pop_req,
    input wire logic [7:0] pop_data,
    // Core control
    output logic core_hold,
    output logic i_mask,
    output logic fetch_next,
    output logic vector_valid,
    output logic [15:0] vector_addr,
    output logic restore_valid,
    output logic [15:0] restore_pc,
    output logic [7:0] restore_x,
    output logic [7:0] restore_a,
    output logic [7:0] restore_ccr,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt out
    output logic irq
);

    // *************************************************
    // Declarations
    // *************************************************
    ela_pkg::ela_state_e state;
    ela_pkg::ela_kind_e kind;
    ela_pkg::ela_kind_e next_kind;
    logic rst_any;
    logic reset_q;
    logic [2:0] step;
    logic pop_q;
    logic [2:0] pop_step_q;
    logic [ela_pkg::NUM_SRC:1] req_q;
    logic [ela_pkg::NUM_SRC:1] src_en;
    logic [ela_pkg::NUM_SRC:1] pend;
    logic pend_any;
    logic [ela_pkg::SRC_W-1:0] best_src;
    logic [ela_pkg::SRC_W-1:0] latched_src;
    logic latched_valid;
    logic [7:0] src_en_low;
    logic [7:0] src_en_mid;
    logic [7:0] src_en_high;
    logic [ela_pkg::NUM_EV-1:0] int_status;
    logic [ela_pkg::NUM_EV-1:0] int_enable;
    logic [ela_pkg::NUM_EV-1:0] ev;
    logic [15:0] snap_pc;
    logic [7:0] snap_x;
    logic [7:0] snap_a;
    logic [7:0] snap_ccr;
    logic rti_start;
    logic boundary;
    logic enter_run;
    logic chain;
    logic enter;

    // *************************************************
    // Helpers
    // *************************************************
    // Vector of a maskable flag, two bytes per step down
    function automatic logic [15:0] vec_of(input logic [ela_pkg::SRC_W-1:0] idx);
        logic [15:0] off;
        off = {10'h000, idx - 5'h01, 1'b0};
        vec_of = ela_pkg::VEC_IF1 - off;
    endfunction : vec_of

    // Lowest flag number wins
    function automatic logic [ela_pkg::SRC_W-1:0] pick(input logic [ela_pkg::NUM_SRC:1] p);
        logic [ela_pkg::SRC_W-1:0] sel;
        sel = 5'h00;
        for (int i = ela_pkg::NUM_SRC; i >= 1; i--)
        begin
            if (p[i])
            begin
                sel = ela_pkg::SRC_W'(i);
            end
        end
        pick = sel;
    endfunction : pick

    // *************************************************
    // Reset handling
    // *************************************************
    // Any reset source acts at once, no arbitration
    assign rst_any = srst | (|rst_src);

    // Internal reset out, and memory of a reset for the vector
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            internal_reset <= 1'b1;
            reset_q <= 1'b1;
        end
        else
        begin
            internal_reset <= |rst_src;
            reset_q <= |rst_src;
        end
    end

    // *************************************************
    // Request latching and arbitration
    // *************************************************
    // Registered copy of the request lines
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            req_q <= '0;
        end
        else
        begin
            req_q <= irq_req;
        end
    end

    // Per-source enable and pending term
    for (genvar n = 1; n <= ela_pkg::NUM_SRC; n++)
    begin : g_src
        if (n <= 6)
        begin : g_low
            assign src_en[n] = src_en_low[n + 1];
        end
        else if (n <= 14)
        begin : g_mid
            assign src_en[n] = src_en_mid[n - 7];
        end
        else
        begin : g_high
            assign src_en[n] = src_en_high[n - 15];
        end
        assign pend[n] = req_q[n] & src_en[n];
    end

    assign pend_any = |pend;
    assign best_src = pick(pend);

    // Boundary decisions; requests only act at completion
    assign rti_start = (state == ela_pkg::ST_RUN) & rti_exec & ~reset_q;
    assign boundary = (state == ela_pkg::ST_RUN) & instr_done & ~rti_exec & ~reset_q;
    assign enter_run = boundary & (brk_req | swi_exec | (pend_any & ~i_mask));
    assign chain = (state == ela_pkg::ST_RESUME) & pend_any & ~restore_ccr[ela_pkg::CCR_I_BIT];
    assign enter = enter_run | chain;

    // Entry kind: break, then trap, then hardware
    always_comb
    begin
        if (chain)
        begin
            next_kind = ela_pkg::KIND_HW;
        end
        else if (brk_req)
        begin
            next_kind = ela_pkg::KIND_BRK;
        end
        else if (swi_exec)
        begin
            next_kind = ela_pkg::KIND_SWI;
        end
        else
        begin
            next_kind = ela_pkg::KIND_HW;
        end
    end

    // *************************************************
    // Sequencer
    // *************************************************
    // Stacking, vector and return sequence
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            state <= ela_pkg::ST_RUN;
            step <= 3'h0;
            kind <= ela_pkg::KIND_HW;
        end
        else
        begin
            unique case (state)
                ela_pkg::ST_RUN:
                begin
                    step <= 3'h0;
                    if (rti_start)
                    begin
                        state <= ela_pkg::ST_POP;
                    end
                    else if (enter_run)
                    begin
                        state <= ela_pkg::ST_PUSH;
                        kind <= next_kind;
                    end
                end
                ela_pkg::ST_PUSH:
                begin
                    step <= step + 3'h1;
                    if (step == ela_pkg::PUSH_LAST)
                    begin
                        state <= ela_pkg::ST_VEC;
                    end
                end
                ela_pkg::ST_VEC:
                begin
                    state <= ela_pkg::ST_RUN;
                end
                ela_pkg::ST_POP:
                begin
                    step <= step + 3'h1;
                    if (step == ela_pkg::PUSH_LAST)
                    begin
                        state <= ela_pkg::ST_POPW;
                    end
                end
                ela_pkg::ST_POPW:
                begin
                    state <= ela_pkg::ST_RESUME;
                end
                ela_pkg::ST_RESUME:
                begin
                    step <= 3'h0;
                    if (chain)
                    begin
                        state <= ela_pkg::ST_PUSH;
                        kind <= next_kind;
                    end
                    else
                    begin
                        state <= ela_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // Latched source stays fixed through stacking
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            latched_src <= 5'h00;
            latched_valid <= 1'b0;
        end
        else if (enter)
        begin
            latched_src <= best_src;
            latched_valid <= 1'b1;
        end
        else if (state == ela_pkg::ST_VEC)
        begin
            latched_valid <= 1'b0;
        end
    end

    // Snapshot of core registers at entry
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            snap_pc <= 16'h0000;
            snap_x <= 8'h00;
            snap_a <= 8'h00;
            snap_ccr <= 8'h00;
        end
        else if (chain)
        begin
            snap_pc <= restore_pc;
            snap_x <= restore_x;
            snap_a <= restore_a;
            snap_ccr <= restore_ccr;
        end
        else if (enter_run)
        begin
            if (next_kind == ela_pkg::KIND_HW)
            begin
                snap_pc <= core_pc - ela_pkg::HW_PC_ADJ;
            end
            else
            begin
                snap_pc <= core_pc;
            end
            snap_x <= core_x;
            snap_a <= core_a;
            snap_ccr <= core_ccr;
            snap_ccr[ela_pkg::CCR_I_BIT] <= i_mask;
        end
    end

    // *************************************************
    // Stack port
    // *************************************************
    // Push order PC low, PC high, X, A, CCR; no index high
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            push_valid <= 1'b0;
            push_data <= 8'h00;
        end
        else
        begin
            push_valid <= (state == ela_pkg::ST_PUSH);
            unique case (step)
                3'h0: push_data <= snap_pc[7:0];
                3'h1: push_data <= snap_pc[15:8];
                3'h2: push_data <= snap_x;
                3'h3: push_data <= snap_a;
                default: push_data <= snap_ccr;
            endcase
        end
    end

    // Pop strobe; data comes back next cycle
    assign pop_req = (state == ela_pkg::ST_POP);

    // Track which popped byte arrives
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            pop_q <= 1'b0;
            pop_step_q <= 3'h0;
        end
        else
        begin
            pop_q <= pop_req;
            pop_step_q <= step;
        end
    end

    // Restore CCR, A, X, PC high, PC low
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            restore_pc <= 16'h0000;
            restore_x <= 8'h00;
            restore_a <= 8'h00;
            restore_ccr <= 8'h00;
        end
        else if (pop_q)
        begin
            unique case (pop_step_q)
                3'h0: restore_ccr <= pop_data;
                3'h1: restore_a <= pop_data;
                3'h2: restore_x <= pop_data;
                3'h3: restore_pc[15:8] <= pop_data;
                default: restore_pc[7:0] <= pop_data;
            endcase
        end
    end

    // Restore handed to the core
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            restore_valid <= 1'b0;
        end
        else
        begin
            restore_valid <= (state == ela_pkg::ST_POPW);
        end
    end

    // *************************************************
    // Core control
    // *************************************************
    assign core_hold = (state != ela_pkg::ST_RUN);

    // Mask bit: set after stacking, restored on return
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            i_mask <= 1'b1;
        end
        else if (state == ela_pkg::ST_VEC)
        begin
            i_mask <= 1'b1;
        end
        else if (state == ela_pkg::ST_RESUME)
        begin
            i_mask <= restore_ccr[ela_pkg::CCR_I_BIT];
        end
        else if (state == ela_pkg::ST_RUN && cli_req)
        begin
            i_mask <= 1'b0;
        end
        else if (state == ela_pkg::ST_RUN && sei_req)
        begin
            i_mask <= 1'b1;
        end
    end

    // Vector constant; reset vector bypasses arbitration
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            vector_valid <= 1'b0;
            vector_addr <= ela_pkg::VEC_RESET;
        end
        else if (reset_q)
        begin
            vector_valid <= 1'b1;
            vector_addr <= ela_pkg::VEC_RESET;
        end
        else if (state == ela_pkg::ST_VEC)
        begin
            vector_valid <= 1'b1;
            if (kind == ela_pkg::KIND_HW)
            begin
                vector_addr <= vec_of(latched_src);
            end
            else
            begin
                vector_addr <= ela_pkg::VEC_SWI;
            end
        end
        else
        begin
            vector_valid <= 1'b0;
        end
    end

    // No entry: go on with the next instruction
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            fetch_next <= 1'b0;
        end
        else
        begin
            fetch_next <= (boundary & ~enter_run) | ((state == ela_pkg::ST_RESUME) & ~chain);
        end
    end

    // *************************************************
    // Event flags and interrupt out
    // *************************************************
    assign ev[ela_pkg::EV_HW] = (state == ela_pkg::ST_VEC) & (kind == ela_pkg::KIND_HW);
    assign ev[ela_pkg::EV_SWI] = (state == ela_pkg::ST_VEC) & (kind == ela_pkg::KIND_SWI);
    assign ev[ela_pkg::EV_BRK] = (state == ela_pkg::ST_VEC) & (kind == ela_pkg::KIND_BRK);
    assign ev[ela_pkg::EV_RTI] = (state == ela_pkg::ST_RESUME);

    // Sticky status; a new event beats a clear
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            int_status <= '0;
        end
        else if (reg_wr && reg_addr == ela_pkg::ADDR_INT_CLEAR)
        begin
            int_status <= (int_status & ~reg_wdata[ela_pkg::NUM_EV-1:0]) | ev;
        end
        else
        begin
            int_status <= int_status | ev;
        end
    end

    assign irq = |(int_status & int_enable);

    // *************************************************
    // Register port
    // *************************************************
    // Writable registers
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            int_enable <= ela_pkg::INT_EN_RESET;
            src_en_low <= ela_pkg::SRC_EN_RESET & ela_pkg::LOW_USED;
            src_en_mid <= ela_pkg::SRC_EN_RESET;
            src_en_high <= ela_pkg::SRC_EN_RESET & ela_pkg::HIGH_USED;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                ela_pkg::ADDR_INT_ENABLE: int_enable <= reg_wdata[ela_pkg::NUM_EV-1:0];
                ela_pkg::ADDR_SRC_EN_LOW: src_en_low <= reg_wdata & ela_pkg::LOW_USED;
                ela_pkg::ADDR_SRC_EN_MID: src_en_mid <= reg_wdata;
                ela_pkg::ADDR_SRC_EN_HIGH: src_en_high <= reg_wdata & ela_pkg::HIGH_USED;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, else zero
    always_ff @(posedge clk)
    begin
        if (rst_any)
        begin
            reg_rdata <= ela_pkg::PEND_RESET;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                ela_pkg::ADDR_PEND_LOW: reg_rdata <= {req_q[6:1], 2'b00};
                ela_pkg::ADDR_PEND_MID: reg_rdata <= req_q[14:7];
                ela_pkg::ADDR_PEND_HIGH: reg_rdata <= {5'h00, req_q[17:15]};
                ela_pkg::ADDR_INT_STATUS: reg_rdata <= {4'h0, int_status};
                ela_pkg::ADDR_INT_ENABLE: reg_rdata <= {4'h0, int_enable};
                ela_pkg::ADDR_SRC_EN_LOW: reg_rdata <= src_en_low;
                ela_pkg::ADDR_SRC_EN_MID: reg_rdata <= src_en_mid;
                ela_pkg::ADDR_SRC_EN_HIGH: reg_rdata <= src_en_high;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : ela_top

`default_nettype wire

// ### testbench/ela_checker_assertions.sv
// Port checker for the exception latch and arbiter
`timescale 1ns/1ps
`default_nettype none
module ela_checker
(
    // Watched ports
    input wire logic clk,
    input wire logic srst,
    input wire logic [5:0] rst_src,
    input wire logic internal_reset,
    input wire logic [ela_pkg::NUM_SRC:1] irq_req,
    input wire logic instr_done,
    input wire logic swi_exec,
    input wire logic rti_exec,
    input wire logic brk_req,
    input wire logic push_valid,
    input wire logic core_hold,
    input wire logic i_mask,
    input wire logic fetch_next,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr,
    input wire logic restore_valid,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    logic [1:0] live;
    logic idle_bd;
    // Two cycles past any reset
    always_ff @(posedge clk)
    begin
        live <= {live[0], !srst && !internal_reset && !(|rst_src)};
    end
    assign idle_bd = live[1] && !core_hold && instr_done && !rti_exec;
    default clocking @(posedge clk); endclocking
    default disable iff (srst || internal_reset || (|rst_src));
    a_trap_vector:
        assert property (idle_bd && (swi_exec || brk_req) |-> ##7 vector_valid && vector_addr == ela_pkg::VEC_SWI)
        else $error("trap entry missed its vector");
    a_push_five:
        assert property (idle_bd && (swi_exec || brk_req) |-> ##1 !push_valid ##1 push_valid [*5] ##1 !push_valid)
        else $error("stacking not five bytes");
    a_mask_on_vector:
        assert property (vector_valid |-> i_mask)
        else $error("mask clear at vector");
    a_masked_fetch:
        assert property (idle_bd && i_mask && !swi_exec && !brk_req |=> fetch_next && !core_hold)
        else $error("masked boundary did not continue");
    a_no_abort:
        assert property (live[1] && !core_hold && !instr_done && !rti_exec |=> !core_hold)
        else $error("entry without boundary");
    a_return_restore:
        assert property (live[1] && !core_hold && rti_exec |-> ##7 restore_valid)
        else $error("return did not restore");
    a_pend_mid:
        assert property (live[1] && reg_rd && reg_addr == ela_pkg::ADDR_PEND_MID |=> reg_rdata == $past(irq_req[14:7], 2))
        else $error("middle flags wrong");
    a_pend_low_zero:
        assert property (reg_rd && reg_addr == ela_pkg::ADDR_PEND_LOW |=> reg_rdata[1:0] == 2'h0)
        else $error("low flag bits not zero");
    a_pend_high:
        assert property (live[1] && reg_rd && reg_addr == ela_pkg::ADDR_PEND_HIGH |=> reg_rdata == {5'h00, $past(irq_req[17:15], 2)})
        else $error("high flags wrong");
    a_reset_vector:
        assert property (disable iff (|rst_src) srst ##1 !srst |=> vector_valid && vector_addr == ela_pkg::VEC_RESET)
        else $error("no reset vector");
    a_source_reset:
        assert property (disable iff (srst) (|rst_src) |=> internal_reset)
        else $error("reset source ignored");
    // Main scenarios
    c_hw_entry: cover property (vector_valid && vector_addr < ela_pkg::VEC_SWI);
    c_trap_entry: cover property (idle_bd && swi_exec);
    c_chain: cover property (restore_valid ##1 core_hold);
endmodule : ela_checker
bind ela_top ela_checker chk (.*);
`default_nettype wire

// ### testbench/ela_stack_model.sv
// Core stack memory facing the stacking port
`timescale 1ns/1ps
`default_nettype none
module ela_stack_model
(
    // Clock
    input wire logic clk,
    // Stack port
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic pop_req,
    output logic [7:0] pop_data
);
    logic [7:0] mem [0:63];
    logic [5:0] sp = 6'h00;
    initial pop_data = 8'h5A;
    // LIFO; pop data stands one cycle
    always @(posedge clk)
    begin
        if (push_valid)
        begin
            mem[sp] <= push_data;
            sp <= sp + 6'h01;
        end
        else if (pop_req)
        begin
            pop_data <= mem[sp - 6'h01];
            sp <= sp - 6'h01;
        end
        else
            pop_data <= ~pop_data;  // Stale data inverted in cycles with no push or pop
    end
endmodule : ela_stack_model
`default_nettype wire

// ### testbench/ela_top_bench.sv
// Self-checking bench for the exception latch and arbiter
`timescale 1ns/1ps
`default_nettype none
module ela_top_bench;
    logic clk = 1'b0, srst = 1'b1;
    logic [5:0] rst_src = 6'h00;
    logic [17:1] irq_req = 17'h00000;
    logic instr_done = 1'b0, swi_exec = 1'b0, rti_exec = 1'b0, brk_req = 1'b0, cli_req = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic internal_reset, push_valid, pop_req, core_hold, i_mask, vector_valid, restore_valid, irq;
    logic [7:0] push_data, pop_data, restore_x, restore_a, restore_ccr, reg_rdata;
    logic [15:0] vector_addr, restore_pc;
    int n_fail = 0, comparisons = 0;
    // Clock of 40 ns
    always #20 clk = ~clk;
    ela_top dut (.*, .sei_req(1'b0), .core_pc(16'h1234), .core_x(8'h5C), .core_a(8'hA3), .core_ccr(8'h00),
        .fetch_next());
    ela_stack_model stk (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chkb
    // Boundary pulse: plain, trap, break or return
    task automatic bnd(input logic s, input logic r, input logic b);
        @(posedge clk);
        {instr_done, swi_exec, rti_exec, brk_req} <= {!r, s, r, b};
        @(posedge clk);
        {instr_done, swi_exec, rti_exec, brk_req} <= 4'h0;
    endtask : bnd
    // Wait for vector or restore pulse, then compare its address
    task automatic wt(input logic r, input logic [15:0] exp);
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk);
            if ((r ? restore_valid : vector_valid) === 1'b1)
                break;
        end
        chkb(r ? restore_valid : vector_valid, 1'b1);
        chk(r ? restore_pc : vector_addr, exp);
    endtask : wt
    // Read strobe, data compared in the next cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic t_reset;
        chkb(i_mask, 1'b1);
        chk(vector_addr, ela_pkg::VEC_RESET);
        rd(ela_pkg::ADDR_PEND_MID, ela_pkg::PEND_RESET);
        rd(ela_pkg::ADDR_INT_ENABLE, 8'h00);
        rd(ela_pkg::ADDR_SRC_EN_LOW, ela_pkg::LOW_USED);
        $display("reset test done");
    endtask : t_reset
    task automatic t_regs;
        @(posedge clk) irq_req <= {3'h5, 8'hA5, 6'h33};
        bnd(1'b0, 1'b0, 1'b0);
        rd(ela_pkg::ADDR_PEND_HIGH, 8'h05);
        wr(ela_pkg::ADDR_PEND_MID, 8'h5A);
        rd(ela_pkg::ADDR_PEND_MID, 8'hA5);
        rd(ela_pkg::ADDR_PEND_LOW, 8'hCC);
        rd(16'hFE07, 8'h00);
        @(posedge clk) irq_req <= 17'h00000;
        $display("status test done");
    endtask : t_regs
    task automatic t_trap;
        for (int k = 0; k < 2; k++)
        begin
            bnd(k == 0, 1'b0, k == 1);
            wt(1'b0, ela_pkg::VEC_SWI);
            bnd(1'b0, 1'b1, 1'b0);
            wt(1'b1, 16'h1234);
            chk({restore_x, restore_a}, 16'h5CA3);
            chk({8'h00, restore_ccr}, 16'h0008);
        end
        rd(ela_pkg::ADDR_INT_STATUS, 8'h0E);
        wr(ela_pkg::ADDR_INT_ENABLE, 8'h04);
        chkb(irq, 1'b1);
        wr(ela_pkg::ADDR_INT_CLEAR, 8'h0E);
        chkb(irq, 1'b0);
        $display("trap test done");
    endtask : t_trap
    task automatic t_hw;
        @(posedge clk) {cli_req, irq_req[9], irq_req[3]} <= 3'h7;
        @(posedge clk) cli_req <= 1'b0;
        bnd(1'b0, 1'b0, 1'b0);
        irq_req[2] <= 1'b1;
        wt(1'b0, 16'hFFF6);
        @(posedge clk) irq_req[3:2] <= 2'h0;
        chkb(i_mask, 1'b1);
        bnd(1'b0, 1'b1, 1'b0);
        wt(1'b1, 16'h1233);
        wt(1'b0, 16'hFFEA);
        @(posedge clk) irq_req[9] <= 1'b0;
        bnd(1'b0, 1'b1, 1'b0);
        wt(1'b1, 16'h1233);
        $display("hardware test done");
    endtask : t_hw
    task automatic t_rst;
        @(posedge clk) rst_src <= 6'h10;
        repeat (2) @(posedge clk);
        rst_src <= 6'h00;
        @(negedge clk);
        chkb(internal_reset, 1'b1);
        wt(1'b0, ela_pkg::VEC_RESET);
        chkb(i_mask, 1'b1);
        $display("reset source test done");
    endtask : t_rst
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset;
        t_regs;
        t_trap;
        t_hw;
        t_rst;
        conclude;
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        n_fail++;
        conclude;
    end
endmodule : ela_top_bench
`default_nettype wire
